// *** rtl/dtr_dtc_fmt.sv ***
// Purpose: Selects one of the four wire bytes of an error record
// Assumes: Record fields as in the package
// Notes:   Purely combinational
module dtr_dtc_fmt
	import dtr_pkg::*;
(
	input  wire dtr_rec_s  rec, // Error record
	input  wire logic [1:0] sel, // Byte within the record
	output dtr_byte_t       out  // Selected byte
);
	// Byte layout of one error code
	always_comb begin
		case (sel)
			2'h0:    out = rec.spn[7:0];
			2'h1:    out = rec.spn[15:8];
			2'h2:    out = {rec.spn[18:16], rec.fmi};
			default: out = {1'b0, rec.oc};
		endcase
	end
endmodule : dtr_dtc_fmt

// *** rtl/dtr_err_mem.sv ***
// Purpose: Store of previously active error records
// Assumes: Writes come from the error handler, reads from the responder
// Notes:   Read data come from a register, one clock after the address
module dtr_err_mem
	import dtr_pkg::*;
#(
	parameter int DEPTH = MAX_ERR // Slots in the list
) (
	input  wire logic ref_clk,    // Clock
	dtr_mem_if.mem    mem         // Read and write port
);
	dtr_rec_s store [DEPTH];      // Record array, no reset needed

	// ----------------------------------------
	// Write and registered read
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (mem.wr_en && (int'(mem.wr_addr) < DEPTH)) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
		// Out of range reads return the last slot rather than X
		mem.rd_data <= store[(int'(mem.rd_addr) < DEPTH) ? mem.rd_addr : 5'(DEPTH - 1)];
	end
endmodule : dtr_err_mem

// *** rtl/dtr_mem_if.sv ***
// Purpose: Carrier between responder core and its error list memory
// Assumes: One clock domain
// Notes:   Read data lag the address by one clock
interface dtr_mem_if;
	import dtr_pkg::*;
	logic           wr_en;   // Write strobe from error handler
	logic [4:0]     wr_addr; // Write slot
	dtr_rec_s       wr_data; // Record written
	logic [4:0]     rd_addr; // Read slot
	dtr_rec_s       rd_data; // Registered read record
	modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
	modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface : dtr_mem_if

// *** rtl/dtr_pkg.sv ***
// Purpose: Shared constants and types of the trouble code responder
// Assumes: Frames are 29-bit identifier CAN frames, byte 0 in data bits 7:0
// Notes:   Summary of the responder behaviour follows
//
// Summary of operation
// - One stored error gives one 8-byte frame
// - No stored errors gives single frame with zeroed lamp and error bytes, other bytes 0xff
// - Several errors start with BAM announcement frame while the session is free
// - Lamp byte follows only currently active errors, except the empty report, which always carries no lamp
// - Session taken with several errors stored gives global busy acknowledgement
// - Clear request clears occurrence counters, 29 max
// - Finished clear answered with positive acknowledgement
// - Clear during clear denied, no second clear
// - Fault reset leaves hold state when allowed
// - Successful fault reset answered with positive acknowledgement
// - Refused fault reset gives negative acknowledgement
// - Stored error report sent only on request
// - Lamp codes and error byte field layout
// - Acknowledgement filler, address and PGN bytes
// - Request carries 3-byte PGN, decoded to handler
package dtr_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int            MAX_ERR     = 30;      // Deepest error list one transfer holds
	localparam logic [4:0]    CLR_PER_REQ = 5'h1d;   // Counters one clear request may reset
	localparam logic [3:0]    REQ_DLC     = 4'h3;    // Length of a request frame
	localparam logic [3:0]    FRAME_DLC   = 4'h8;    // Length of every reply frame
	localparam logic [7:0]    HDR_BYTES   = 8'h02;   // Lamp and flash bytes
	localparam logic [7:0]    DT_BYTES    = 8'h07;   // Payload bytes per data packet
	// ----------------------------------------
	// Group numbers and identifiers
	// ----------------------------------------
	localparam logic [23:0]   PGN_DM2     = 24'h00fecb; // Stored error report
	localparam logic [23:0]   PGN_DM3     = 24'h00fecc; // Occurrence counter clear
	localparam logic [23:0]   PGN_DM11    = 24'h00fed3; // Fault status reset
	localparam logic [20:0]   ID_DM2      = 21'h18fecb; // Single report frame
	localparam logic [20:0]   ID_BAM      = 21'h1cecff; // Announcement frame
	localparam logic [20:0]   ID_DT       = 21'h1cebff; // Data packet frame
	localparam logic [20:0]   ID_ACK      = 21'h18e8ff; // Acknowledgement frame
	// ----------------------------------------
	// Byte values
	// ----------------------------------------
	localparam logic [7:0]    BAM_CTRL    = 8'h20;   // Announcement control byte
	localparam logic [7:0]    ACK_POS     = 8'h00;   // Positive
	localparam logic [7:0]    ACK_NEG     = 8'h01;   // Negative
	localparam logic [7:0]    ACK_DENY    = 8'h02;   // Access denied or busy
	localparam logic [7:0]    LAMP_NONE   = 8'h00;   // No active error
	localparam logic [7:0]    LAMP_AMBER  = 8'h04;   // Info or warning
	localparam logic [7:0]    LAMP_RED    = 8'h10;   // Severe or critical
	localparam logic [7:0]    FILL        = 8'hff;   // Flash, reserved and padding
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [7:0] dtr_byte_t;                  // One frame byte
	typedef struct packed {
		logic [18:0] spn;                            // Suspect part number
		logic [4:0]  fmi;                            // Failure mode
		logic [6:0]  oc;                             // Occurrence count
	} dtr_rec_s;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,                           // Waiting for a request
		ST_GATHER = 2'b01,                           // Collecting packet bytes
		ST_SEND   = 2'b10                            // Frame offered to transmitter
	} dtr_state_e;
endpackage : dtr_pkg

// *** rtl/dtr_responder.sv ***
// Purpose: Answers stored error, counter clear and fault reset requests
// Assumes: Received request frames arrive already filtered to this node
// Notes:   One request handled at a time; req_ready holds off the rest
module dtr_responder
	import dtr_pkg::*;
(
	input  wire logic        ref_clk,        // 40 MHz clock
	input  wire logic        rst_b,          // Async reset, active low
	input  wire logic [7:0]  node_addr,      // Own source address
	input  wire logic        req_valid,      // Request frame present
	output logic             req_ready,      // Request taken this cycle
	input  wire logic [7:0]  req_src,        // Requester address
	input  wire logic [3:0]  req_dlc,        // Request length
	input  wire logic [23:0] req_pgn,        // Requested group number
	output logic             tx_valid,       // Reply frame offered
	input  wire logic        tx_ready,       // Transmitter takes frame
	output logic [28:0]      tx_id,          // Reply identifier
	output logic [3:0]       tx_dlc,         // Reply length
	output logic [63:0]      tx_data,        // Reply bytes, byte 0 low
	input  wire logic [4:0]  prev_err_count, // Stored errors in list
	input  wire logic        act_any,        // Some error currently active
	input  wire logic        act_severe,     // Severe error currently active
	input  wire logic        dm1_bam_busy,   // Other traffic holds session
	output logic             bam_busy,       // This block holds session
	input  wire logic        err_wr_en,      // Error list write
	input  wire logic [4:0]  err_wr_addr,    // Error list slot
	input  wire dtr_rec_s    err_wr_rec,     // Error list record
	output logic             occ_clr_start,  // Counter clear pulse
	output logic [4:0]       occ_clr_max,    // Counters per clear
	input  wire logic        occ_clr_done,   // Counter clear finished pulse
	input  wire logic        fault_hold,     // Handler in fault hold
	input  wire logic        prev_severe,    // Severe error stored
	output logic             fault_clear     // Leave fault hold pulse
);
	import dtr_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	dtr_mem_if   mif ();                     // Memory carrier
	dtr_state_e  state;                      // Engine state
	logic        take;                       // Request accepted
	logic        req_ok;                     // Length is right
	logic        bam_on;                     // Multi packet transfer open
	logic        dm2_take;                   // Stored error report taken
	logic [7:0]  nbytes;                     // Payload length
	logic [7:0]  npkt;                       // Packets in transfer
	logic [7:0]  seq;                        // Current packet number
	logic [7:0]  pos;                        // First payload byte of packet
	logic [2:0]  gj;                         // Gather step
	logic [7:0]  bcur;                       // Byte fetched this step
	logic [7:0]  bprev;                      // Byte whose record is ready
	logic [7:0]  boff;                       // bprev minus header
	dtr_byte_t   g [6];                      // First six bytes; the seventh goes straight out
	dtr_byte_t   rec_byte;                   // Byte out of formatter
	dtr_byte_t   pay_byte;                   // Resolved payload byte
	dtr_byte_t   lamp;                       // Current lamp code
	logic        clr_busy;                   // Counter clear running
	logic        ack_pend;                   // Clear done, ack owed
	logic [7:0]  clr_src;                    // Who asked for the clear
	logic [7:0]  bam_bytes;                  // Length for live count

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	assign mif.wr_en   = err_wr_en;
	assign mif.wr_addr = err_wr_addr;
	assign mif.wr_data = err_wr_rec;

	dtr_err_mem #(.DEPTH(MAX_ERR)) u_mem (
		.ref_clk (ref_clk),
		.mem     (mif.mem)
	);

	dtr_dtc_fmt u_fmt (
		.rec (mif.rd_data),
		.sel (boff[1:0]),
		.out (rec_byte)
	);

	// ----------------------------------------
	// Combinational helpers
	// ----------------------------------------
	// Lamp tracks active errors only, not the stored ones
	assign lamp      = act_severe ? LAMP_RED : (act_any ? LAMP_AMBER : LAMP_NONE);
	assign req_ready = (state == ST_IDLE) && !ack_pend;
	assign take      = req_valid && req_ready;
	assign req_ok    = (req_dlc == REQ_DLC);
	assign tx_valid  = (state == ST_SEND);
	assign bam_busy  = bam_on;
	assign occ_clr_max = CLR_PER_REQ;
	// Two header bytes plus four per error
	assign bam_bytes   = HDR_BYTES + {1'b0, prev_err_count, 2'b00};
	assign dm2_take    = take && req_ok && (req_pgn == PGN_DM2);
	assign bcur      = pos + {5'h00, gj};
	assign boff      = bprev - HDR_BYTES;
	// Record slot of the byte being fetched
	assign mif.rd_addr = (bcur < HDR_BYTES) ? 5'h00 : 5'((bcur - HDR_BYTES) >> 2);

	// Header, record or padding byte for a payload position
	always_comb begin
		if (bprev == 8'h00) begin
			pay_byte = lamp;
		end else if (bprev == 8'h01 || bprev >= nbytes) begin
			pay_byte = FILL;
		end else begin
			pay_byte = rec_byte;
		end
	end

	// ----------------------------------------
	// Request engine
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state   <= ST_IDLE;
			bam_on  <= 1'b0;
			nbytes  <= 8'h00;
			npkt    <= 8'h00;
			seq     <= 8'h00;
			pos     <= 8'h00;
			gj      <= 3'h0;
			bprev   <= 8'h00;
			tx_id   <= 29'h0000000;
			tx_dlc  <= 4'h0;
			tx_data <= 64'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					gj  <= 3'h0;
					pos <= 8'h00;
					seq <= 8'h00;
					if (ack_pend) begin
						// Owed clear result goes first, it was asked first
						tx_id   <= {ID_ACK, node_addr};
						tx_dlc  <= FRAME_DLC;
						tx_data <= {PGN_DM3[23:16], PGN_DM3[15:8], PGN_DM3[7:0], clr_src,
							FILL, FILL, FILL, ACK_POS};
						state   <= ST_SEND;
					end else if (take && req_ok) begin
						nbytes <= bam_bytes;
						npkt   <= 8'((bam_bytes + DT_BYTES - 8'h01) / DT_BYTES);
						tx_id  <= {ID_ACK, node_addr};
						tx_dlc <= FRAME_DLC;
						case (req_pgn)
							PGN_DM2: begin
								if (prev_err_count == 5'h00) begin
									tx_id   <= {ID_DM2, node_addr};
									tx_data <= {FILL, FILL, 8'h00, 8'h00, 8'h00, 8'h00,
										FILL, LAMP_NONE};
									state   <= ST_SEND;
								end else if (prev_err_count == 5'h01) begin
									// Single error frame built by the gather walk
									state   <= ST_GATHER;
								end else if (dm1_bam_busy) begin
									tx_data <= {PGN_DM2[23:16], PGN_DM2[15:8], PGN_DM2[7:0], req_src,
										FILL, FILL, FILL, ACK_DENY};
									state   <= ST_SEND;
								end else begin
									tx_id   <= {ID_BAM, node_addr};
									tx_data <= {PGN_DM2[23:16], PGN_DM2[15:8], PGN_DM2[7:0], FILL,
										8'((bam_bytes + DT_BYTES - 8'h01) / DT_BYTES),
										8'h00, bam_bytes, BAM_CTRL};
									bam_on  <= 1'b1;
									state   <= ST_SEND;
								end
							end
							PGN_DM3: begin
								// Busy clear is denied at once, no second clear starts
								tx_data <= {PGN_DM3[23:16], PGN_DM3[15:8], PGN_DM3[7:0], req_src,
									FILL, FILL, FILL, ACK_DENY};
								state   <= clr_busy ? ST_SEND : ST_IDLE;
							end
							PGN_DM11: begin
								tx_data <= {PGN_DM11[23:16], PGN_DM11[15:8], PGN_DM11[7:0], req_src,
									FILL, FILL, FILL,
									(fault_hold && !prev_severe) ? ACK_POS : ACK_NEG};
								state   <= ST_SEND;
							end
							default: begin
								// Other groups belong to other handlers
								state <= ST_IDLE;
							end
						endcase
					end
				end
				ST_GATHER: begin
					// Address goes out at step j, its byte lands at step j+1
					gj    <= gj + 3'h1;
					bprev <= bcur;
					if (gj == 3'h7) begin
						tx_dlc <= FRAME_DLC;
						if (bam_on) begin
							tx_id   <= {ID_DT, node_addr};
							// Last byte lands this very edge, so take it from the mux
							tx_data <= {pay_byte, g[5], g[4], g[3], g[2], g[1], g[0], seq};
						end else begin
							tx_id   <= {ID_DM2, node_addr};
							tx_data <= {FILL, pay_byte, g[5], g[4], g[3], g[2], g[1], g[0]};
						end
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (tx_ready) begin
						gj <= 3'h0;
						if (bam_on && seq < npkt) begin
							// Next numbered packet of the transfer
							seq   <= seq + 8'h01;
							pos   <= (seq == 8'h00) ? 8'h00 : pos + DT_BYTES;
							state <= ST_GATHER;
						end else begin
							bam_on <= 1'b0;
							state  <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Gathered bytes
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < 6; k++) begin : g_byte
			// Each slot fills at the step after its address went out
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					g[k] <= FILL;
				end else if (state == ST_GATHER && gj == 3'(k + 1)) begin
					g[k] <= pay_byte;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Counter clear bookkeeping
	// ----------------------------------------
	// Done wins over the owed-ack clear so no result is lost
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_busy      <= 1'b0;
			ack_pend      <= 1'b0;
			clr_src       <= 8'h00;
			occ_clr_start <= 1'b0;
		end else begin
			occ_clr_start <= 1'b0;
			if (take && req_ok && req_pgn == PGN_DM3 && !clr_busy) begin
				clr_busy      <= 1'b1;
				clr_src       <= req_src;
				occ_clr_start <= 1'b1;
			end else if (clr_busy && occ_clr_done) begin
				clr_busy <= 1'b0;
			end
			if (clr_busy && occ_clr_done) begin
				ack_pend <= 1'b1;
			end else if (state == ST_IDLE && ack_pend) begin
				ack_pend <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Fault reset pulse
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_clear <= 1'b0;
		end else begin
			fault_clear <= take && req_ok && req_pgn == PGN_DM11
				&& fault_hold && !prev_severe;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_take(logic [23:0] p);
		take && req_ok && req_pgn == p;
	endsequence

	sequence s_ack(logic [7:0] c, logic [23:0] p);
		tx_valid && tx_id[28:8] == ID_ACK && tx_data[7:0] == c && tx_data[63:40] == p;
	endsequence

	chk_single_frame: assert property (
		s_take(PGN_DM2) ##0 (prev_err_count == 5'h01) |-> ##9 (tx_valid && tx_id[28:8] == ID_DM2
			&& tx_data[15:8] == FILL && tx_data[63:48] == 16'hffff))
		else $error("single error frame wrong");
	chk_empty_frame: assert property (
		s_take(PGN_DM2) ##0 (prev_err_count == 5'h00 && !ack_pend) |=> tx_valid
			&& tx_data == 64'hffff_0000_0000_ff00)
		else $error("empty report frame wrong");
	chk_bam_announce: assert property (
		s_take(PGN_DM2) ##0 (prev_err_count > 5'h01 && !dm1_bam_busy) |=> tx_valid
			&& tx_id[28:8] == ID_BAM && tx_data[7:0] == BAM_CTRL && tx_data[63:40] == 24'h00fecb
			&& tx_data[15:8] == HDR_BYTES + {1'b0, $past(prev_err_count), 2'b00})
		else $error("announcement frame wrong");
	chk_lamp_active: assert property (
		tx_valid && tx_id[28:8] == ID_DT && tx_data[7:0] == 8'h01 && !act_any |-> tx_data[15:8] == LAMP_NONE)
		else $error("lamp byte shows stored errors");
	chk_busy_ack: assert property (
		s_take(PGN_DM2) ##0 (prev_err_count > 5'h01 && dm1_bam_busy) |=> s_ack(ACK_DENY, PGN_DM2)
			and tx_data[39:32] == $past(req_src))
		else $error("busy acknowledgement wrong");
	chk_clear_pulse: assert property (
		s_take(PGN_DM3) ##0 !clr_busy |=> occ_clr_start ##1 !occ_clr_start)
		else $error("clear pulse wrong");
	chk_clear_ack: assert property (
		clr_busy && occ_clr_done && state == ST_IDLE |=> ##1 s_ack(ACK_POS, PGN_DM3))
		else $error("clear result not acknowledged");
	chk_clear_deny: assert property (
		s_take(PGN_DM3) ##0 clr_busy |=> s_ack(ACK_DENY, PGN_DM3) and !occ_clr_start)
		else $error("second clear not denied");
	chk_fault_reset: assert property (
		s_take(PGN_DM11) ##0 (fault_hold && !prev_severe) |=> fault_clear and s_ack(ACK_POS, PGN_DM11))
		else $error("fault reset not acknowledged");
	chk_fault_refuse: assert property (
		s_take(PGN_DM11) ##0 (!fault_hold || prev_severe) |=> !fault_clear and s_ack(ACK_NEG, PGN_DM11))
		else $error("fault reset not refused");
	chk_ack_filler: assert property (
		tx_valid && tx_id[28:8] == ID_ACK |-> tx_data[31:8] == 24'hffffff && tx_dlc == FRAME_DLC)
		else $error("acknowledgement filler wrong");
	chk_no_spont: assert property (
		$rose(tx_valid) && tx_id[28:8] == ID_DM2 |-> $past(dm2_take) || $past(dm2_take, 9))
		else $error("report frame sent unasked");
endmodule : dtr_responder

// *** verification/diag_trouble_code_responder_test.sv ***
// Purpose: Self-checking bench of the trouble code responder
// Assumes: Host model takes frames and runs counter clears
// Notes:   Frame bytes are compared as 64-bit words, byte 0 low
module diag_trouble_code_responder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dtr_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0;                 // Clock, reset, request
	logic        act_any = 1'b0, act_severe = 1'b0, dm1_bam_busy = 1'b0;         // Error status
	logic        err_wr_en = 1'b0, fault_hold = 1'b0, prev_severe = 1'b0;        // Handler levels
	logic [7:0]  node_addr = 8'h51, req_src = 8'h2a;                             // Addresses
	logic [3:0]  req_dlc = 4'h3, stall = 4'h0;                                   // Lengths, stall
	logic [23:0] req_pgn = 24'h000000;                                           // Requested group
	logic [4:0]  prev_err_count = 5'h00, err_wr_addr = 5'h00;                    // Error list
	dtr_rec_s    err_wr_rec = '0;                                                // Record written
	logic        req_ready, tx_valid, tx_ready, bam_busy, occ_clr_start;         // Design outputs, tx_ready from host
	logic        occ_clr_done, fault_clear, got;                                 // Pulses
	logic [28:0] tx_id;                                                          // Reply id
	logic [3:0]  tx_dlc;                                                         // Reply length
	logic [63:0] tx_data, got_data;                                              // Reply bytes
	logic [32:0] got_hdr;                                                        // Captured header
	logic [4:0]  occ_clr_max;                                                    // Counters per clear
	int          n_mismatch = 0, n_tests = 0, n_start = 0, n_fclr = 0;           // Tallies
	dtr_responder uut (.ref_clk, .rst_b, .node_addr, .req_valid, .req_ready, .req_src, .req_dlc,
		.req_pgn, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .prev_err_count, .act_any,
		.act_severe, .dm1_bam_busy, .bam_busy, .err_wr_en, .err_wr_addr, .err_wr_rec,
		.occ_clr_start, .occ_clr_max, .occ_clr_done, .fault_hold, .prev_severe, .fault_clear);
	dtr_host_model host (.ref_clk, .rst_b, .stall, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data,
		.occ_clr_start, .occ_clr_done, .got, .got_hdr, .got_data);
	always #12.5 ref_clk = ~ref_clk;
	// Pulse tallies, read before the edge lands its updates
	always @(posedge ref_clk) begin
		n_start += int'(occ_clr_start === 1'b1);
		n_fclr  += int'(fault_clear === 1'b1);
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] act);
		n_tests++;
		if (act !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", what, exp, act);
		end
	endtask : cmp
	// Request held until taken at a ready edge
	task automatic req(input logic [23:0] pgn);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_pgn   <= pgn;
		do @(negedge ref_clk); while (req_ready !== 1'b1);
		@(posedge ref_clk);
		req_valid <= 1'b0;
	endtask : req
	// Next frame taken by the host must match
	task automatic frm(input string what, input logic [20:0] id, input logic [63:0] data);
		do @(negedge ref_clk); while (got !== 1'b1);
		cmp({what, " hdr"}, {31'h0, 4'h8, id, node_addr}, {31'h0, got_hdr});
		cmp(what, data, got_data);
		@(posedge ref_clk);
	endtask : frm
	task automatic wr(input logic [4:0] a, input dtr_rec_s r);
		@(posedge ref_clk);
		err_wr_en   <= 1'b1;
		err_wr_addr <= a;
		err_wr_rec  <= r;
		@(posedge ref_clk);
		err_wr_en   <= 1'b0;
	endtask : wr
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_report();
		act_any <= 1'b1;
		req(PGN_DM2);
		frm("empty", ID_DM2, 64'hffff00000000ff00);
		wr(5'h00, {19'h7f30d, 5'h11, 7'h01});
		prev_err_count <= 5'h01;
		req(PGN_DM2);
		frm("single", ID_DM2, 64'hffff01f1f30dff04);
		act_severe <= 1'b1;
		req(PGN_DM2);
		frm("single red", ID_DM2, 64'hffff01f1f30dff10);
		act_severe <= 1'b0;
		$display("report tests done");
	endtask : t_report
	// Four errors with a slow transmitter, nothing active now
	task automatic t_bam();
		wr(5'h01, {19'h7f308, 5'h0b, 7'h06});
		wr(5'h00, {19'h7f183, 5'h02, 7'h06});
		wr(5'h02, {19'h000a8, 5'h03, 7'h01});
		wr(5'h03, {19'h7f30f, 5'h10, 7'h06});
		act_any        <= 1'b0;
		stall          <= 4'h3;
		prev_err_count <= 5'h04;
		req(PGN_DM2);
		frm("announce", ID_BAM, 64'h00fecbff03001220);
		cmp("session open", 64'd1, {63'h0, bam_busy});
		frm("packet1", ID_DT, 64'h0806e2f183ff0001);
		frm("packet2", ID_DT, 64'h010300a806ebf302);
		frm("packet3", ID_DT, 64'hffffff06f0f30f03);
		cmp("session closed", 64'd0, {63'h0, bam_busy});
		stall        <= 4'h0;
		dm1_bam_busy <= 1'b1;
		prev_err_count <= 5'h02;
		req(PGN_DM2);
		frm("busy", ID_ACK, 64'h00fecb2affffff02);
		dm1_bam_busy <= 1'b0;
		$display("transfer tests done");
	endtask : t_bam
	// Second clear while the first runs is denied
	task automatic t_clear();
		req(PGN_DM3);
		req(PGN_DM3);
		frm("deny", ID_ACK, 64'h00fecc2affffff02);
		frm("cleared", ID_ACK, 64'h00fecc2affffff00);
		cmp("clear starts", 64'd1, 64'(n_start));
		// Two more clears so every counter is reached
		repeat (2) begin
			req(PGN_DM3);
			frm("cleared again", ID_ACK, 64'h00fecc2affffff00);
		end
		cmp("clear starts", 64'd3, 64'(n_start));
		cmp("clear max", 64'd29, {59'h0, occ_clr_max});
		$display("clear tests done");
	endtask : t_clear
	task automatic t_fault();
		fault_hold <= 1'b1;
		// Wrong length and unknown group are taken silently
		req_dlc    <= 4'h8;
		req(PGN_DM11);
		req_dlc    <= 4'h3;
		req(24'h00fed0);
		req(PGN_DM11);
		frm("reset ok", ID_ACK, 64'h00fed32affffff00);
		prev_severe <= 1'b1;
		req(PGN_DM11);
		frm("severe", ID_ACK, 64'h00fed32affffff01);
		fault_hold  <= 1'b0;
		prev_severe <= 1'b0;
		req(PGN_DM11);
		frm("no hold", ID_ACK, 64'h00fed32affffff01);
		cmp("fault clears", 64'd1, 64'(n_fclr));
		$display("fault tests done");
	endtask : t_fault
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_report();
		t_bam();
		t_clear();
		t_fault();
		stop_test();
	end
	// Whole run is under 700 cycles; far more means a hang
	initial begin
		#50us;
		n_mismatch++;
		stop_test();
	end
endmodule : diag_trouble_code_responder_test

// *** verification/dtr_host_model.sv ***
// Purpose: Far-side model: frame transmitter and occurrence counter clear engine
// Assumes: One clock; stall sets how long a frame waits for tx_ready
// Notes:   A clear finishes 40 cycles after its start pulse
module dtr_host_model
(
	input  wire logic        ref_clk,       // Clock
	input  wire logic        rst_b,         // Reset, active low
	input  wire logic [3:0]  stall,         // Wait before taking a frame
	input  wire logic        tx_valid,      // Frame offered
	output logic             tx_ready,      // Frame taken
	input  wire logic [28:0] tx_id,         // Frame identifier
	input  wire logic [3:0]  tx_dlc,        // Frame length
	input  wire logic [63:0] tx_data,       // Frame bytes
	input  wire logic        occ_clr_start, // Clear start
	output logic             occ_clr_done,  // Clear finished
	output logic             got,           // Frame captured
	output logic [32:0]      got_hdr,       // Captured length and id
	output logic [63:0]      got_data       // Captured bytes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt; // Cycles frame has waited
	logic [5:0] clr_cnt;  // Clear time left
	// Transmitter: takes a frame after stall cycles, one per handshake
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ready <= 1'b0;
			wait_cnt <= 4'h0;
			got      <= 1'b0;
		end else begin
			tx_ready <= tx_valid && !tx_ready && wait_cnt == stall;
			wait_cnt <= (tx_valid && !tx_ready && wait_cnt != stall) ? wait_cnt + 4'h1 : 4'h0;
			got      <= tx_valid && tx_ready;
		end
	end
	// Capture what crossed; slow slot so the bench can read it late
	always_ff @(posedge ref_clk) begin
		if (tx_valid && tx_ready) begin
			got_hdr  <= {tx_dlc, tx_id};
			got_data <= tx_data;
		end
	end
	// Clear engine: long enough for a second request to land meanwhile
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clr_cnt      <= 6'h00;
			occ_clr_done <= 1'b0;
		end else begin
			occ_clr_done <= clr_cnt == 6'h01;
			clr_cnt      <= occ_clr_start ? 6'h28 : (clr_cnt != 6'h00 ? clr_cnt - 6'h01 : 6'h00);
		end
	end
endmodule : dtr_host_model
